//--- design/pcc_compare_array.sv
`default_nettype none
`include "pcc_map.svh"

module pcc_compare_array import pcc_pkg::*; (
  input wire logic ref_clk, // System clock, 250 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire logic countPulse, // Counter increment request
  input wire logic [7:0] sfrAddr, // Register address
  input wire logic sfrWr, // Register write strobe
  input wire logic [7:0] sfrWrData, // Register write data
  input wire logic sfrRd, // Register read strobe
  output logic [7:0] sfrRdData, // Register read data
  input wire logic [`PCC_NUM_MOD-1:0] eventPinIn, // Event pins in
  output logic [`PCC_NUM_MOD-1:0] eventPinOut, // Event pins out
  output logic [`PCC_NUM_MOD-1:0] eventPinOe, // Pin output enables
  output logic irqReq, // Interrupt request level
  output logic wdtReset // Watchdog reset pulse
);

  localparam int NM = `PCC_NUM_MOD;

  // ************************************************************
  // State
  // ************************************************************
  pcc_count_t counter;
  pcc_count_t next_counter;
  logic cntStep;
  logic next_cntStep;
  logic ovfFlag;
  logic next_ovfFlag;
  logic runBit;
  logic next_runBit;
  logic [7:0] cntMode;
  logic [7:0] next_cntMode;
  logic [NM-1:0] evtFlag;
  logic [NM-1:0] next_evtFlag;
  logic [NM-1:0] cmpHold;
  logic [NM-1:0] next_cmpHold;
  logic [7:0] modeReg [NM];
  logic [7:0] next_modeReg [NM];
  logic [7:0] capHi [NM];
  logic [7:0] next_capHi [NM];
  logic [7:0] capLo [NM];
  logic [7:0] next_capLo [NM];
  logic [NM-1:0] next_pinOut;
  logic [NM-1:0] next_pinOe;
  logic next_irqReq;
  logic next_wdtReset;
  logic [7:0] next_rdData;

  logic [NM-1:0] riseSeen;
  logic [NM-1:0] fallSeen;
  logic [NM-1:0] matchHit;
  logic [NM-1:0] capHit;
  logic [NM-1:0] togHit;
  logic [NM-1:0] pwmMode;
  logic [NM-1:0] pwmHigh;
  logic [NM-1:0] pinDrive;
  logic [NM-1:0] irqEnBits;
  logic countNow;
  logic lowWrap;

  pcc_pin_sync uSync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .pinIn(eventPinIn),
    .riseSeen(riseSeen),
    .fallSeen(fallSeen)
  );

  for (genvar g = 0; g < NM; g++)
  begin : gUnit
    pcc_cmp_unit uUnit (
      .mode(modeReg[g]),
      .count(counter),
      .cmpWord({capHi[g], capLo[g]}),
      .hold(cmpHold[g]),
      .countStep(cntStep),
      .riseSeen(riseSeen[g]),
      .fallSeen(fallSeen[g]),
      .matchHit(matchHit[g]),
      .captureHit(capHit[g]),
      .toggleHit(togHit[g]),
      .pwmMode(pwmMode[g]),
      .pwmHigh(pwmHigh[g]),
      .pinDrive(pinDrive[g])
    );
    assign irqEnBits[g] = modeReg[g][`PCC_MODE_IRQ_EN];
  end

  assign countNow = runBit && countPulse;
  assign lowWrap = cntStep && (counter[7:0] == `PCC_RST_BYTE);

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    next_counter = countNow ? 16'(counter + 16'h0001) : counter;
    next_cntStep = countNow;
    next_ovfFlag = ovfFlag || (countNow && counter == `PCC_COUNT_TOP);
    next_runBit = runBit;
    next_cntMode = cntMode;
    next_evtFlag = evtFlag | matchHit | capHit;
    next_cmpHold = cmpHold;
    next_pinOut = eventPinOut;
    next_rdData = sfrRdData;
    for (int i = 0; i < NM; i++)
    begin
      next_modeReg[i] = modeReg[i];
      next_capHi[i] = capHi[i];
      next_capLo[i] = capLo[i];
    end

    // Software writes; hardware sets below still win
    if (sfrWr)
    begin
      if (sfrAddr == `PCC_ADDR_CTRL_FLAGS)
      begin
        next_ovfFlag = sfrWrData[`PCC_CTRL_OVF] ||
          (countNow && counter == `PCC_COUNT_TOP);
        next_runBit = sfrWrData[`PCC_CTRL_RUN];
        next_evtFlag = sfrWrData[NM-1:0] | matchHit | capHit;
      end
      if (sfrAddr == `PCC_ADDR_CNT_MODE)
        next_cntMode = sfrWrData & `PCC_CMODE_WR_MASK;
      if (sfrAddr == `PCC_ADDR_CNT_LO)
        next_counter = {counter[15:8], sfrWrData};
      if (sfrAddr == `PCC_ADDR_CNT_HI)
        next_counter = {sfrWrData, counter[7:0]};
      for (int i = 0; i < NM; i++)
      begin
        if (sfrAddr == 8'(`PCC_ADDR_MODE_BASE + 8'(i)))
          next_modeReg[i] = sfrWrData & `PCC_MODE_WR_MASK;
        if (sfrAddr == 8'(`PCC_ADDR_CMP_LO_BASE + 8'(i)))
        begin
          next_capLo[i] = sfrWrData;
          next_cmpHold[i] = 1'b1;
        end
        if (sfrAddr == 8'(`PCC_ADDR_CMP_HI_BASE + 8'(i)))
        begin
          next_capHi[i] = sfrWrData;
          next_cmpHold[i] = 1'b0;
        end
      end
    end

    // Hardware updates of pairs and pins
    for (int i = 0; i < NM; i++)
    begin
      if (capHit[i])
      begin
        next_capHi[i] = counter[15:8];
        next_capLo[i] = counter[7:0];
      end
      if (pwmMode[i] && lowWrap)
        next_capLo[i] = capHi[i];
      if (pwmMode[i])
        next_pinOut[i] = pwmHigh[i];
      else if (togHit[i])
        next_pinOut[i] = !eventPinOut[i];
    end
    next_pinOe = pinDrive;

    next_irqReq = |(evtFlag & irqEnBits) ||
      (ovfFlag && cntMode[`PCC_CMODE_OVF_IRQ]);
    next_wdtReset = matchHit[`PCC_WDT_MOD] &&
      cntMode[`PCC_CMODE_WDT_EN];

    // Read port, unmapped addresses return zero
    if (sfrRd)
    begin
      next_rdData = `PCC_RST_BYTE;
      if (sfrAddr == `PCC_ADDR_CTRL_FLAGS)
      begin
        next_rdData[`PCC_CTRL_OVF] = ovfFlag;
        next_rdData[`PCC_CTRL_RUN] = runBit;
        next_rdData[NM-1:0] = evtFlag;
      end
      if (sfrAddr == `PCC_ADDR_CNT_MODE)
        next_rdData = cntMode;
      if (sfrAddr == `PCC_ADDR_CNT_LO)
        next_rdData = counter[7:0];
      if (sfrAddr == `PCC_ADDR_CNT_HI)
        next_rdData = counter[15:8];
      for (int i = 0; i < NM; i++)
      begin
        if (sfrAddr == 8'(`PCC_ADDR_MODE_BASE + 8'(i)))
          next_rdData = modeReg[i];
        if (sfrAddr == 8'(`PCC_ADDR_CMP_LO_BASE + 8'(i)))
          next_rdData = capLo[i];
        if (sfrAddr == 8'(`PCC_ADDR_CMP_HI_BASE + 8'(i)))
          next_rdData = capHi[i];
      end
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      counter <= `PCC_RST_COUNT;
      cntStep <= 1'b0;
      ovfFlag <= 1'b0;
      runBit <= 1'b0;
      cntMode <= `PCC_RST_BYTE;
      evtFlag <= '0;
      cmpHold <= '0;
      for (int i = 0; i < NM; i++)
      begin
        modeReg[i] <= `PCC_RST_BYTE;
        capHi[i] <= `PCC_RST_BYTE;
        capLo[i] <= `PCC_RST_BYTE;
      end
      eventPinOut <= '0;
      eventPinOe <= '0;
      irqReq <= 1'b0;
      wdtReset <= 1'b0;
      sfrRdData <= `PCC_RST_BYTE;
    end
    else if (ce)
    begin
      counter <= next_counter;
      cntStep <= next_cntStep;
      ovfFlag <= next_ovfFlag;
      runBit <= next_runBit;
      cntMode <= next_cntMode;
      evtFlag <= next_evtFlag;
      cmpHold <= next_cmpHold;
      for (int i = 0; i < NM; i++)
      begin
        modeReg[i] <= next_modeReg[i];
        capHi[i] <= next_capHi[i];
        capLo[i] <= next_capLo[i];
      end
      eventPinOut <= next_pinOut;
      eventPinOe <= next_pinOe;
      irqReq <= next_irqReq;
      wdtReset <= next_wdtReset;
      sfrRdData <= next_rdData;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_count_wrap;
    ce && countNow && counter == `PCC_COUNT_TOP &&
      !(sfrWr && (sfrAddr == `PCC_ADDR_CNT_LO ||
        sfrAddr == `PCC_ADDR_CNT_HI));
  endsequence

  sequence s_flag_kept;
    ce && !(sfrWr && sfrAddr == `PCC_ADDR_CTRL_FLAGS);
  endsequence

  a_capture_load: assert property (ce && capHit[1] |=>
    {capHi[1], capLo[1]} == $past(counter))
    else $error("capture pair not loaded from counter");

  a_flag_sticky: assert property (evtFlag[1] ##0 s_flag_kept |=>
    evtFlag[1])
    else $error("event flag dropped without software");

  a_irq_gate: assert property (ce && (evtFlag & irqEnBits) != '0 |=>
    irqReq)
    else $error("interrupt missing for enabled flag");

  a_match_flag: assert property (ce && matchHit[2] |=> evtFlag[2])
    else $error("match did not set event flag");

  a_hold_blocks: assert property (ce && cmpHold[2] && !pwmMode[2] |=>
    eventPinOut[2] == $past(eventPinOut[2]))
    else $error("output moved while comparator suspended");

  a_hso_toggle: assert property (ce && togHit[2] && !pwmMode[2] |=>
    eventPinOut[2] != $past(eventPinOut[2]))
    else $error("output did not toggle on match");

  a_pwm_level: assert property (ce && pwmMode[0] |=>
    eventPinOut[0] == $past(pwmHigh[0]))
    else $error("pulse-width level wrong");

  a_pwm_reload: assert property (ce && pwmMode[1] && lowWrap &&
    !capHit[1] |=> capLo[1] == $past(capHi[1]))
    else $error("duty byte not reloaded on wrap");

  a_wdt_reset: assert property (ce && matchHit[`PCC_WDT_MOD] &&
    cntMode[`PCC_CMODE_WDT_EN] |=> wdtReset ##1 (!$past(ce) ||
    !wdtReset || $past(matchHit[`PCC_WDT_MOD])))
    else $error("watchdog reset not raised on match");

  a_counter_wrap: assert property (s_count_wrap |=>
    ovfFlag && counter == `PCC_RST_COUNT)
    else $error("counter wrap did not set overflow");

endmodule

`default_nettype wire

//--- design/pcc_map.svh
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH

// ************************************************************
// Array size
// ************************************************************
`define PCC_NUM_MOD 5
`define PCC_WDT_MOD 4

// ************************************************************
// Register addresses
// ************************************************************
`define PCC_ADDR_CTRL_FLAGS 8'hC0
`define PCC_ADDR_CNT_MODE 8'hC1
`define PCC_ADDR_CNT_LO 8'hC2
`define PCC_ADDR_CNT_HI 8'hC3
`define PCC_ADDR_MODE_BASE 8'hC4
`define PCC_ADDR_CMP_LO_BASE 8'hEA
`define PCC_ADDR_CMP_HI_BASE 8'hFA

// ************************************************************
// Module mode fields
// ************************************************************
`define PCC_MODE_IRQ_EN 0
`define PCC_MODE_PWM 1
`define PCC_MODE_TOGGLE 2
`define PCC_MODE_MATCH 3
`define PCC_MODE_FALL 4
`define PCC_MODE_RISE 5
`define PCC_MODE_CMP 6
`define PCC_MODE_WR_MASK 8'h7F

// ************************************************************
// Counter control and counter mode fields
// ************************************************************
`define PCC_CTRL_OVF 7
`define PCC_CTRL_RUN 6
`define PCC_CMODE_WDT_EN 6
`define PCC_CMODE_OVF_IRQ 0
`define PCC_CMODE_WR_MASK 8'hC7

// ************************************************************
// Reset values
// ************************************************************
`define PCC_RST_BYTE 8'h00
`define PCC_RST_COUNT 16'h0000
`define PCC_COUNT_TOP 16'hFFFF

`endif

//--- design/pcc_pkg.sv
`default_nettype none
`include "pcc_map.svh"

package pcc_pkg;

  typedef logic [15:0] pcc_count_t;

  typedef enum {PCC_IDLE, PCC_CAPTURE, PCC_TIMER, PCC_HSO, PCC_PWM} pcc_func_t;

  function automatic pcc_func_t pcc_decode(input logic [7:0] m);
    pcc_func_t f;
    f = PCC_IDLE;
    if (m[`PCC_MODE_CMP] && m[`PCC_MODE_PWM])
      f = PCC_PWM;
    else if (m[`PCC_MODE_CMP] && m[`PCC_MODE_MATCH])
      f = m[`PCC_MODE_TOGGLE] ? PCC_HSO : PCC_TIMER;
    else if (!m[`PCC_MODE_CMP] && (m[`PCC_MODE_RISE] || m[`PCC_MODE_FALL]))
      f = PCC_CAPTURE;
    return f;
  endfunction

endpackage

`default_nettype wire

//--- design/pcc_pin_sync.sv
`default_nettype none

`include "pcc_map.svh"

module pcc_pin_sync import pcc_pkg::*; (
  input wire logic ref_clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic [`PCC_NUM_MOD-1:0] pinIn, // Raw event pins
  output logic [`PCC_NUM_MOD-1:0] riseSeen, // Rising edge, one cycle
  output logic [`PCC_NUM_MOD-1:0] fallSeen // Falling edge, one cycle
);

  logic [`PCC_NUM_MOD-1:0] meta;
  logic [`PCC_NUM_MOD-1:0] sync;
  logic [`PCC_NUM_MOD-1:0] last;
  logic [`PCC_NUM_MOD-1:0] next_meta;
  logic [`PCC_NUM_MOD-1:0] next_sync;
  logic [`PCC_NUM_MOD-1:0] next_last;
  logic [2:0] fill;
  logic [2:0] next_fill;

  always_comb
  begin
    next_meta = pinIn;
    next_sync = meta;
    next_last = sync;
    next_fill = {fill[1:0], 1'h1};
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta <= '0;
      sync <= '0;
      last <= '0;
      fill <= 3'h0;
    end
    else if (ce)
    begin
      meta <= next_meta;
      sync <= next_sync;
      last <= next_last;
      fill <= next_fill;
    end
  end

  // ************************************************************
  // Edge detect on settled samples only
  // ************************************************************
  for (genvar g = 0; g < `PCC_NUM_MOD; g++)
  begin : gEdge
    // Held off until last holds a real sample: a pin idling high is no edge
    assign riseSeen[g] = ce && fill[2] && sync[g] && !last[g];
    assign fallSeen[g] = ce && fill[2] && !sync[g] && last[g];
  end

endmodule

`default_nettype wire

//--- design/pcc_cmp_unit.sv
`default_nettype none

`include "pcc_map.svh"

module pcc_cmp_unit import pcc_pkg::*; (
  input wire logic [7:0] mode, // Module mode register
  input wire pcc_count_t count, // Shared counter
  input wire pcc_count_t cmpWord, // Compare/capture pair
  input wire logic hold, // Comparator suspended
  input wire logic countStep, // Counter advanced last cycle
  input wire logic riseSeen, // Pin rising edge
  input wire logic fallSeen, // Pin falling edge
  output logic matchHit, // Compare match this cycle
  output logic captureHit, // Capture event this cycle
  output logic toggleHit, // Output toggle this cycle
  output logic pwmMode, // Module in pulse-width mode
  output logic pwmHigh, // Pulse-width output level
  output logic pinDrive // Module drives its pin
);

  pcc_func_t func;

  always_comb
  begin
    func = pcc_decode(mode);
    captureHit = (func == PCC_CAPTURE) &&
      ((riseSeen && mode[`PCC_MODE_RISE]) ||
       (fallSeen && mode[`PCC_MODE_FALL]));
    // Only a fresh count may match, so a stopped counter cannot refire
    matchHit = (func == PCC_TIMER || func == PCC_HSO) && countStep &&
      !hold && (count == cmpWord);
    toggleHit = matchHit && mode[`PCC_MODE_TOGGLE];
    pwmMode = (func == PCC_PWM);
    pwmHigh = (count[7:0] >= cmpWord[7:0]);
    pinDrive = (func == PCC_HSO) || (func == PCC_PWM);
  end

endmodule

`default_nettype wire

//--- testbench/pcc_pin_model.sv
`default_nettype none

// ****************************************
// Event pin partner
// ****************************************
module pcc_pin_model (
  input wire logic ref_clk, // System clock
  input wire logic [4:0] pinOut, // Module output levels
  input wire logic [4:0] pinOe, // Module output enables
  output var logic [4:0] pinIn // Resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] extLevel = 5'h00;

  // Driven pins read back the module level, others the outside source
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);

  // Delay lets the source answer promptly or late
  task automatic setLevel(input int idx, input logic lvl, input int dly);
    repeat (dly) @(posedge ref_clk);
    extLevel[idx] <= lvl;
  endtask

endmodule

`default_nettype wire

//--- testbench/pcc_compare_array_tb.sv
`default_nettype none
`include "pcc_map.svh"

module pcc_compare_array_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] aCtl = `PCC_ADDR_CTRL_FLAGS;
  localparam logic [7:0] aCmode = `PCC_ADDR_CNT_MODE;
  localparam logic [7:0] aMode = `PCC_ADDR_MODE_BASE;
  localparam logic [7:0] aLo = `PCC_ADDR_CMP_LO_BASE;
  localparam logic [7:0] aHi = `PCC_ADDR_CMP_HI_BASE;

  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic countPulse = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWr = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrRd = 1'b0;
  logic [7:0] sfrRdData;
  logic [4:0] eventPinIn;
  logic [4:0] eventPinOut;
  logic [4:0] eventPinOe;
  logic irqReq;
  logic wdtReset;
  int fails = 0;
  int n_tests = 0;
  int wdtSeen = 0;
  int wdtBase = 0;
  logic [7:0] rv;
  logic [7:0] lo;
  logic [15:0] cv;
  logic [15:0] exp16;
  logic [7:0] capMode [7] = '{8'h21, 8'h21, 8'h10, 8'h10, 8'h30, 8'h30, 8'h00};
  logic [6:0] capLvl = 7'b1010101;
  logic [6:0] capHit = 7'b0111001;
  logic [7:0] pwmCl [4] = '{8'hBF, 8'hC0, 8'hFF, 8'h00};
  logic [1:0] pwmLvl [4] = '{2'b10, 2'b11, 2'b11, 2'b00};

  always #2 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
    if (wdtReset === 1'b1)
      wdtSeen <= wdtSeen + 1;

  pcc_compare_array pcc_compare_array_i (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .countPulse(countPulse),
    .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrWrData(sfrWrData),
    .sfrRd(sfrRd), .sfrRdData(sfrRdData), .eventPinIn(eventPinIn),
    .eventPinOut(eventPinOut), .eventPinOe(eventPinOe), .irqReq(irqReq),
    .wdtReset(wdtReset)
  );

  pcc_pin_model pcc_pin_model_i (
    .ref_clk(ref_clk), .pinOut(eventPinOut), .pinOe(eventPinOe),
    .pinIn(eventPinIn)
  );

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] got,
    input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWr <= 1'b1;
    @(posedge ref_clk);
    sfrWr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Data sampled off the edge, then back onto an edge for the caller
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfrAddr <= a;
    sfrRd <= 1'b1;
    @(posedge ref_clk);
    sfrRd <= 1'b0;
    @(posedge ref_clk);
    #1 d = sfrRdData;
    @(posedge ref_clk);
  endtask

  task automatic rchk(input string n, input logic [7:0] a,
    input logic [7:0] e);
    rd(a, rv);
    check(n, {8'h00, rv}, {8'h00, e});
  endtask

  task automatic setCnt(input logic [15:0] v);
    wr(`PCC_ADDR_CNT_LO, v[7:0]);
    wr(`PCC_ADDR_CNT_HI, v[15:8]);
  endtask

  task automatic count(input int n);
    countPulse <= 1'b1;
    repeat (n) @(posedge ref_clk);
    countPulse <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #200000;
    fails++;
    $display("mismatch timeout expected done seen hang");
    finish_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    check("outs", {4'h0, eventPinOut, eventPinOe, irqReq, wdtReset},
      16'h0);
    for (int m = 0; m < 5; m++)
    begin
      rchk("mode", 8'(aMode + m), 8'h00);
      rchk("cmplo", 8'(aLo + m), 8'h00);
      rchk("cmphi", 8'(aHi + m), 8'h00);
    end
    rchk("ctrl", aCtl, 8'h00);
    wr(aMode, 8'hFF);
    rchk("modebits", aMode, 8'h7F);
    wr(aMode, 8'h00);
    // Counter wrap and run control
    wr(aCtl, 8'h40);
    setCnt(16'hFFFE);
    count(3);
    rchk("cntlo", `PCC_ADDR_CNT_LO, 8'h01);
    rchk("cnthi", `PCC_ADDR_CNT_HI, 8'h00);
    rchk("ovf", aCtl, 8'hC0);
    wr(aCtl, 8'h00);
    count(2);
    rchk("stopped", `PCC_ADDR_CNT_LO, 8'h01);
    // Clock enable low freezes the counter despite run and pulses
    wr(aCtl, 8'h40);
    ce <= 1'b0;
    count(4);
    ce <= 1'b1;
    rchk("frozen", `PCC_ADDR_CNT_LO, 8'h01);
    wr(aCtl, 8'h00);
    // Capture edges on module 1, flag left set throughout
    exp16 = 16'h0000;
    for (int i = 0; i < 7; i++)
    begin
      cv = 16'(16'h1111 * (i + 1));
      wr(aMode + 8'h01, capMode[i]);
      setCnt(cv);
      pcc_pin_model_i.setLevel(1, capLvl[i], i % 3);
      repeat (6) @(posedge ref_clk);
      if (capHit[i])
        exp16 = cv;
      rd(aLo + 8'h01, lo);
      rd(aHi + 8'h01, rv);
      check("capture", {rv, lo}, exp16);
      check("irq", {15'h0, irqReq}, {15'h0, capMode[i][0]});
    end
    rchk("capflag", aCtl, 8'h02);
    wr(aCtl, 8'h00);
    rchk("flagclr", aCtl, 8'h00);
    // High-speed output on module 2
    wr(aMode + 8'h02, 8'h4C);
    wr(aLo + 8'h02, 8'h05);
    wr(aHi + 8'h02, 8'h00);
    wr(aCtl, 8'h40);
    setCnt(16'h0000);
    count(10);
    check("hso", {14'h0, eventPinOe[2], eventPinOut[2]}, 16'h3);
    rchk("hsoflag", aCtl, 8'h44);
    setCnt(16'hFFFA);
    count(12);
    check("hsowrap", {15'h0, eventPinOut[2]}, 16'h0);
    wr(aLo + 8'h02, 8'h08);
    setCnt(16'h0000);
    count(10);
    check("hsohold", {15'h0, eventPinOut[2]}, 16'h0);
    wr(aHi + 8'h02, 8'h00);
    setCnt(16'h0000);
    count(10);
    check("hsoresume", {15'h0, eventPinOut[2]}, 16'h1);
    // Timer on module 3, watchdog on module 4
    wr(aCtl, 8'h40);
    for (int m = 3; m < 5; m++)
    begin
      wr(8'(aMode + m), 8'h48);
      wr(8'(aLo + m), 8'h07);
      wr(8'(aHi + m), 8'h00);
    end
    wr(aCmode, 8'h40);
    setCnt(16'h0000);
    wdtBase = wdtSeen;
    count(10);
    check("wdt", 16'(wdtSeen - wdtBase), 16'h1);
    check("notoggle", {12'h0, eventPinOe[4:3], eventPinOut[4:3]},
      16'h0);
    // Module 2 still runs high-speed output and matches at 8 as well
    rchk("tmrflag", aCtl, 8'h5C);
    wr(aCmode, 8'h00);
    setCnt(16'h0000);
    wdtBase = wdtSeen;
    count(10);
    check("wdtoff", 16'(wdtSeen - wdtBase), 16'h0);
    wr(aMode + 8'h04, 8'h4C);
    wr(aCmode, 8'h40);
    setCnt(16'h0000);
    count(10);
    check("wdttog", {15'h0, eventPinOut[4]}, 16'h1);
    // Pulse width on modules 0 and 1, one shared counter
    wr(aCmode, 8'h00);
    wr(aMode, 8'h43);
    wr(aMode + 8'h01, 8'h42);
    wr(aHi, 8'hC0);
    wr(aHi + 8'h01, 8'h40);
    rchk("pwmhold", aLo, 8'h00);
    setCnt(16'h00FE);
    count(3);
    rchk("pwmload", aLo, 8'hC0);
    for (int i = 0; i < 4; i++)
    begin
      setCnt({8'h00, pwmCl[i]});
      repeat (3) @(posedge ref_clk);
      check("pwmoe", {14'h0, eventPinOe[1:0]}, 16'h3);
      check("pwm", {14'h0, eventPinOut[1:0]}, {14'h0, pwmLvl[i]});
    end
    // Mid-run reset returns every module to idle
    nrst <= 1'b0;
    @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    check("rstouts", {4'h0, eventPinOut, eventPinOe, irqReq, wdtReset},
      16'h0);
    rchk("rstmode", aMode, 8'h00);
    rchk("rstcmp", aLo, 8'h00);
    finish_test();
  end

endmodule

`default_nettype wire
